// ### pmic_safety_config_regs.sv
// Safety, reset/interrupt and spread-spectrum configuration registers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Checksum enable bit steers bus CRC
// - Counter clear bit self-clears when done
// - Restart limit code gives 0/3/15/63
// - Retry bit allows one self-test retry
// - Force bit holds interrupt pin low
// - Lock release works in lock, self-clears
// - Active-flag timeout off/45/95/150 ms
// - Soft-reset length 1/4/16/64 ms
// - Soft-reset bit pulses reset output low
// - Full-restart bit held until restart done
// - Depth bit selects 10% or 5%
// - Divider field gives 1-4 or 4-7
// - Scheme bit selects pseudo-random or triangular
// - Spread enable bit turns spreading on
// - Bus inactivity sets flag, pulls interrupt
module pmic_safety_config_regs #(
  // One timebase scales every ms count together
  parameter int unsigned CYC_PER_MS = pmic_cfg_pkg::CYC_PER_MS,
  parameter int unsigned AFT_CYC1 = pmic_cfg_pkg::AFT_T1_MS * CYC_PER_MS,
  parameter int unsigned AFT_CYC2 = pmic_cfg_pkg::AFT_T2_MS * CYC_PER_MS,
  parameter int unsigned AFT_CYC3 = pmic_cfg_pkg::AFT_T3_MS * CYC_PER_MS,
  parameter int unsigned SRT_CYC0 = pmic_cfg_pkg::SRT_T0_MS * CYC_PER_MS,
  parameter int unsigned SRT_CYC1 = pmic_cfg_pkg::SRT_T1_MS * CYC_PER_MS,
  parameter int unsigned SRT_CYC2 = pmic_cfg_pkg::SRT_T2_MS * CYC_PER_MS,
  parameter int unsigned SRT_CYC3 = pmic_cfg_pkg::SRT_T3_MS * CYC_PER_MS,
  parameter int unsigned BTO_CYC1 = pmic_cfg_pkg::BTO_T1_MS * CYC_PER_MS,
  parameter int unsigned BTO_CYC2 = pmic_cfg_pkg::BTO_T2_MS * CYC_PER_MS,
  parameter int unsigned BTO_CYC3 = pmic_cfg_pkg::BTO_T3_MS * CYC_PER_MS
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rd_data,
  input  wire logic       counter_clear_done,
  input  wire logic       lock_mode_active,
  input  wire logic       unlock_done,
  input  wire logic       full_restart_done,
  input  wire logic       sm_interrupt_req,
  input  wire logic       active_flag_state,
  input  wire logic [1:0] bus_timeout_sel,
  input  wire logic       bus_timeout_clear,
  output logic            bus_checksum_enable,
  output logic            restart_counter_clear,
  output logic      [5:0] safe_state_restart_limit,
  output logic            selftest_retry,
  output logic            lock_release,
  output logic            full_restart_req,
  output logic            active_flag_timeout,
  output logic            bus_timeout_error,
  output logic            interrupt_out_n,
  output logic            reset_out_n,
  output logic            spread_enable,
  output logic            spread_scheme_select,
  output logic            spread_depth_select,
  output logic      [2:0] spread_divider_select
);
  localparam int W = pmic_cfg_pkg::CNT_W;

  typedef enum logic [1:0] {
    SRT_IDLE  = 2'b01,
    SRT_PULSE = 2'b10
  } srt_state_e;

  logic [7:0]   safety_q;
  logic [7:0]   safety_d;
  logic [7:0]   rstint_q;
  logic [7:0]   rstint_d;
  logic [7:0]   spread_q;
  logic [7:0]   spread_d;
  srt_state_e   srt_q;
  srt_state_e   srt_d;
  logic [W-1:0] srt_cnt_q;
  logic [W-1:0] srt_cnt_d;
  logic [W-1:0] srt_lim_q;
  logic [W-1:0] srt_lim_d;
  logic [W-1:0] aft_cnt_q;
  logic [W-1:0] aft_cnt_d;
  logic         aft_exp_q;
  logic         aft_exp_d;
  logic [W-1:0] bto_cnt_q;
  logic [W-1:0] bto_cnt_d;
  logic         bto_err_q;
  logic         bto_err_d;
  logic         int_n_q;
  logic         rst_n_q;
  logic [5:0]   limit_q;
  logic [5:0]   limit_d;
  logic [2:0]   div_q;
  logic [2:0]   div_d;

  wire hit_safety = reg_addr == pmic_cfg_pkg::ADDR_SAFETY;
  wire hit_rstint = reg_addr == pmic_cfg_pkg::ADDR_RSTINT;
  wire hit_spread = reg_addr == pmic_cfg_pkg::ADDR_SPREAD;
  wire wr_safety  = reg_wr_en && hit_safety;
  wire wr_rstint  = reg_wr_en && hit_rstint;
  wire wr_spread  = reg_wr_en && hit_spread;
  wire bus_access = reg_wr_en || reg_rd_en;

  // self-clear bits only set by one
  wire cnt_clr_set = wr_safety && reg_wdata[pmic_cfg_pkg::B_CNT_CLR];
  wire soft_set    = wr_rstint && reg_wdata[pmic_cfg_pkg::B_SOFT];
  wire full_set    = wr_rstint && reg_wdata[pmic_cfg_pkg::B_FULL];
  wire unlock_set  = wr_rstint && reg_wdata[pmic_cfg_pkg::B_UNLOCK] && lock_mode_active;

  wire srt_end = (srt_q == SRT_PULSE) && (srt_cnt_q == srt_lim_q);

  // Plain fields take the write; self-clear bits keep set-over-clear
  wire [7:0] safety_plain = wr_safety ? (reg_wdata & pmic_cfg_pkg::MASK_SAFETY) : safety_q;
  wire [7:0] rstint_plain = wr_rstint ? (reg_wdata & pmic_cfg_pkg::MASK_RSTINT) : rstint_q;

  // clear bit held until counter done
  wire cnt_clr_d = cnt_clr_set || (safety_q[pmic_cfg_pkg::B_CNT_CLR] && !counter_clear_done);
  wire unlock_d  = unlock_set || (rstint_q[pmic_cfg_pkg::B_UNLOCK] && !unlock_done);
  // soft bit cleared at pulse end
  wire soft_d    = soft_set || (rstint_q[pmic_cfg_pkg::B_SOFT] && !srt_end);
  wire full_d    = full_set || (rstint_q[pmic_cfg_pkg::B_FULL] && !full_restart_done);

  always_comb
  begin
    safety_d = safety_plain;
    safety_d[pmic_cfg_pkg::B_CNT_CLR] = cnt_clr_d;
    rstint_d = rstint_plain;
    rstint_d[pmic_cfg_pkg::B_UNLOCK] = unlock_d;
    rstint_d[pmic_cfg_pkg::B_SOFT] = soft_d;
    rstint_d[pmic_cfg_pkg::B_FULL] = full_d;
  end

  assign spread_d = wr_spread ? (reg_wdata & pmic_cfg_pkg::MASK_SPREAD) : spread_q;

  wire [1:0] limit_code = safety_d[pmic_cfg_pkg::B_LIMIT +: 2];
  assign limit_d = (limit_code == 2'h0) ? pmic_cfg_pkg::LIMIT_C0 :
                   (limit_code == 2'h1) ? pmic_cfg_pkg::LIMIT_C1 :
                   (limit_code == 2'h2) ? pmic_cfg_pkg::LIMIT_C2 : pmic_cfg_pkg::LIMIT_C3;

  wire [2:0] div_base = spread_d[pmic_cfg_pkg::B_SCHEME] ? pmic_cfg_pkg::DIV_BASE_TRI
                                                          : pmic_cfg_pkg::DIV_BASE_PRB;
  assign div_d = div_base + {1'b0, spread_d[pmic_cfg_pkg::B_DIV +: 2]};

  // pulse length, code 10 taken as 16 ms
  wire [1:0] srt_code = rstint_q[pmic_cfg_pkg::B_SRT +: 2];
  wire [W-1:0] srt_sel = (srt_code == 2'h0) ? W'(SRT_CYC0 - 1) :
                         (srt_code == 2'h1) ? W'(SRT_CYC1 - 1) :
                         (srt_code == 2'h2) ? W'(SRT_CYC2 - 1) : W'(SRT_CYC3 - 1);

  always_comb
  begin
    srt_d = srt_q;
    srt_cnt_d = srt_cnt_q;
    srt_lim_d = srt_lim_q;
    unique case (srt_q)
      SRT_IDLE:
      begin
        if (rstint_q[pmic_cfg_pkg::B_SOFT])
        begin
          srt_d = SRT_PULSE;
          srt_cnt_d = '0;
          srt_lim_d = srt_sel;
        end
      end
      SRT_PULSE:
      begin
        if (srt_end)
        begin
          srt_d = SRT_IDLE;
        end
        else
        begin
          srt_cnt_d = srt_cnt_q + W'(1);
        end
      end
      default:
      begin
        srt_d = SRT_IDLE;
      end
    endcase
  end

  wire [1:0] aft_code = rstint_q[pmic_cfg_pkg::B_AFT +: 2];
  wire [W-1:0] aft_lim = (aft_code == 2'h1) ? W'(AFT_CYC1 - 1) :
                         (aft_code == 2'h2) ? W'(AFT_CYC2 - 1) : W'(AFT_CYC3 - 1);
  wire aft_run = active_flag_state && (aft_code != 2'h0);
  wire aft_hit = aft_run && !aft_exp_q && (aft_cnt_q == aft_lim);

  assign aft_cnt_d = (!aft_run || aft_exp_q) ? '0 : aft_cnt_q + W'(1);
  assign aft_exp_d = aft_run && (aft_exp_q || aft_hit);

  wire [W-1:0] bto_lim = (bus_timeout_sel == 2'h1) ? W'(BTO_CYC1 - 1) :
                         (bus_timeout_sel == 2'h2) ? W'(BTO_CYC2 - 1) : W'(BTO_CYC3 - 1);
  wire bto_run = (bus_timeout_sel != 2'h0) && !bus_access;
  wire bto_hit = bto_run && (bto_cnt_q == bto_lim);

  assign bto_cnt_d = (!bto_run || bto_hit) ? '0 : bto_cnt_q + W'(1);
  assign bto_err_d = bto_hit || (bto_err_q && !bus_timeout_clear);

  wire int_low_d = rstint_d[pmic_cfg_pkg::B_FORCE] || sm_interrupt_req || bto_err_d;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      safety_q <= pmic_cfg_pkg::RST_SAFETY;
      rstint_q <= pmic_cfg_pkg::RST_RSTINT;
      spread_q <= pmic_cfg_pkg::RST_SPREAD;
      limit_q  <= pmic_cfg_pkg::LIMIT_C0;
      div_q    <= pmic_cfg_pkg::DIV_BASE_PRB;
    end
    else
    begin
      safety_q <= safety_d;
      rstint_q <= rstint_d;
      spread_q <= spread_d;
      limit_q  <= limit_d;
      div_q    <= div_d;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      srt_q     <= SRT_IDLE;
      srt_cnt_q <= '0;
      srt_lim_q <= '0;
      rst_n_q   <= 1'b1;
    end
    else
    begin
      srt_q     <= srt_d;
      srt_cnt_q <= srt_cnt_d;
      srt_lim_q <= srt_lim_d;
      rst_n_q   <= srt_d != SRT_PULSE;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aft_cnt_q <= '0;
      aft_exp_q <= 1'b0;
      bto_cnt_q <= '0;
      bto_err_q <= 1'b0;
      int_n_q   <= 1'b1;
    end
    else
    begin
      aft_cnt_q <= aft_cnt_d;
      aft_exp_q <= aft_exp_d;
      bto_cnt_q <= bto_cnt_d;
      bto_err_q <= bto_err_d;
      int_n_q   <= !int_low_d;
    end
  end

  assign reg_rd_data = hit_safety ? safety_q :
                       hit_rstint ? rstint_q :
                       hit_spread ? spread_q : 8'h00;

  assign bus_checksum_enable   = safety_q[pmic_cfg_pkg::B_CRC];
  assign restart_counter_clear = safety_q[pmic_cfg_pkg::B_CNT_CLR];
  assign safe_state_restart_limit = limit_q;
  assign selftest_retry        = safety_q[pmic_cfg_pkg::B_RETRY];
  assign lock_release          = rstint_q[pmic_cfg_pkg::B_UNLOCK];
  assign full_restart_req      = rstint_q[pmic_cfg_pkg::B_FULL];
  assign active_flag_timeout   = aft_exp_q;
  assign bus_timeout_error     = bto_err_q;
  assign interrupt_out_n       = int_n_q;
  assign reset_out_n           = rst_n_q;
  assign spread_enable         = spread_q[pmic_cfg_pkg::B_SPR_EN];
  assign spread_scheme_select  = spread_q[pmic_cfg_pkg::B_SCHEME];
  assign spread_depth_select   = spread_q[pmic_cfg_pkg::B_DEPTH];
  assign spread_divider_select = div_q;

endmodule : pmic_safety_config_regs
`default_nettype wire

// ### pmic_cfg_pkg.sv
// Package: offsets, field layout, reset values and timing counts of the configuration bank
`default_nettype none
package pmic_cfg_pkg;
  localparam logic [7:0] ADDR_SAFETY = 8'h16;
  localparam logic [7:0] ADDR_RSTINT = 8'h17;
  localparam logic [7:0] ADDR_SPREAD = 8'h18;
  localparam logic [7:0] RST_SAFETY  = 8'h00;
  localparam logic [7:0] RST_RSTINT  = 8'h0C;
  localparam logic [7:0] RST_SPREAD  = 8'h00;
  localparam logic [7:0] MASK_SAFETY = 8'h6D;
  localparam logic [7:0] MASK_RSTINT = 8'hFF;
  localparam logic [7:0] MASK_SPREAD = 8'h1F;
  localparam int B_CRC      = 6;
  localparam int B_CNT_CLR  = 5;
  localparam int B_LIMIT    = 2;
  localparam int B_RETRY    = 0;
  localparam int B_FORCE    = 7;
  localparam int B_UNLOCK   = 6;
  localparam int B_AFT      = 4;
  localparam int B_SRT      = 2;
  localparam int B_SOFT     = 1;
  localparam int B_FULL     = 0;
  localparam int B_DEPTH    = 4;
  localparam int B_DIV      = 2;
  localparam int B_SCHEME   = 1;
  localparam int B_SPR_EN   = 0;
  localparam logic [5:0] LIMIT_C0 = 6'h00;
  localparam logic [5:0] LIMIT_C1 = 6'h03;
  localparam logic [5:0] LIMIT_C2 = 6'h0F;
  localparam logic [5:0] LIMIT_C3 = 6'h3F;
  localparam logic [2:0] DIV_BASE_PRB = 3'h1;
  localparam logic [2:0] DIV_BASE_TRI = 3'h4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int AFT_T1_MS  = 45;
  localparam int AFT_T2_MS  = 95;
  localparam int AFT_T3_MS  = 150;
  localparam int SRT_T0_MS  = 1;
  localparam int SRT_T1_MS  = 4;
  localparam int SRT_T2_MS  = 16;
  localparam int SRT_T3_MS  = 64;
  localparam int BTO_T1_MS  = 16;
  localparam int BTO_T2_MS  = 128;
  localparam int BTO_T3_MS  = 1024;
  localparam int CNT_W      = 27;
endpackage : pmic_cfg_pkg
`default_nettype wire

// ### pmic_safety_config_regs_chk.sv
// Checker: port-level properties of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module pmic_safety_config_regs_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       counter_clear_done,
  input wire logic       lock_mode_active,
  input wire logic       full_restart_done,
  input wire logic       sm_interrupt_req,
  input wire logic       active_flag_state,
  input wire logic       bus_checksum_enable,
  input wire logic       restart_counter_clear,
  input wire logic [5:0] safe_state_restart_limit,
  input wire logic       lock_release,
  input wire logic       full_restart_req,
  input wire logic       active_flag_timeout,
  input wire logic       bus_timeout_error,
  input wire logic       interrupt_out_n,
  input wire logic       reset_out_n,
  input wire logic       spread_enable,
  input wire logic       spread_scheme_select,
  input wire logic       spread_depth_select,
  input wire logic [2:0] spread_divider_select
);
  wire logic w16     = reg_wr_en && reg_addr == 8'h16;
  wire logic w17     = reg_wr_en && reg_addr == 8'h17;
  wire logic w18     = reg_wr_en && reg_addr == 8'h18;
  wire logic soft_wr = w17 && reg_wdata[1];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_CRC: assert property (w16 |=> bus_checksum_enable == $past(reg_wdata[6]))
    else $error("checksum enable not taken from write");
  AST_LIMIT: assert property (w16 && reg_wdata[3:2] == 2'b11 |-> ##2 safe_state_restart_limit == 6'h3F)
    else $error("restart limit code 11 not 63");
  AST_CLR: assert property (restart_counter_clear && counter_clear_done && !(w16 && reg_wdata[5])
    |=> !restart_counter_clear)
    else $error("counter clear bit kept after done");
  AST_HOLD: assert property (full_restart_req && !full_restart_done |=> full_restart_req)
    else $error("full restart request dropped early");
  AST_LOCK: assert property (w17 && reg_wdata[6] && !lock_mode_active && !lock_release |=> !lock_release)
    else $error("unlock taken outside lock mode");
  AST_INT: assert property ((w17 && reg_wdata[7]) || sm_interrupt_req |=> !interrupt_out_n)
    else $error("interrupt pin not low");
  AST_SOFT: assert property ($fell(reset_out_n) |-> $past(soft_wr, 2))
    else $error("reset pulse without request two cycles before");
  AST_SPR: assert property (w18 |=> {spread_depth_select, spread_scheme_select, spread_enable}
    == {$past(reg_wdata[4]), $past(reg_wdata[1]), $past(reg_wdata[0])})
    else $error("spread control bits wrong");
  AST_DIV: assert property (w18 |-> ##2 spread_divider_select
    == ($past(reg_wdata[1], 2) ? 3'h4 : 3'h1) + {1'b0, $past(reg_wdata[3:2], 2)})
    else $error("spread divider wrong");
  AST_AFT: assert property ($rose(active_flag_timeout) |-> active_flag_state)
    else $error("timeout flag outside active-flag state");
  AST_BTO: assert property (bus_timeout_error |-> !interrupt_out_n)
    else $error("inactivity flag without interrupt");
endmodule : pmic_safety_config_regs_chk
bind pmic_safety_config_regs pmic_safety_config_regs_chk u_chk (.mclk, .rst, .reg_wr_en, .reg_addr,
  .reg_wdata, .counter_clear_done, .lock_mode_active, .full_restart_done, .sm_interrupt_req,
  .active_flag_state, .bus_checksum_enable, .restart_counter_clear, .safe_state_restart_limit,
  .lock_release, .full_restart_req, .active_flag_timeout, .bus_timeout_error, .interrupt_out_n,
  .reset_out_n, .spread_enable, .spread_scheme_select, .spread_depth_select, .spread_divider_select);
`default_nettype wire

// ### pmic_host_model.sv
// Partner model: state machine acknowledging pending self-clearing requests
`timescale 1ns/1ps
`default_nettype none
module pmic_host_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic restart_counter_clear,
  input  wire logic lock_release,
  input  wire logic full_restart_req,
  output logic      counter_clear_done,
  output logic      unlock_done,
  output logic      full_restart_done
);
  logic [2:0] pend, s0, s1, s2, s3, s4, s5, done;
  assign pend = {restart_counter_clear, lock_release, full_restart_req};
  assign {counter_clear_done, unlock_done, full_restart_done} = done;
  // slow done
  // Answers late so pending bits stay readable for a while
  always_ff @(negedge mclk or posedge rst)
  begin
    if (rst)
    begin
      {s0, s1, s2, s3, s4, s5, done} <= '0;
    end
    else
    begin
      s0   <= pend;
      s1   <= s0;
      s2   <= s1;
      s3   <= s2;
      s4   <= s3;
      s5   <= s4;
      done <= s0 & s1 & s2 & s3 & s4 & s5 & pend;
    end
  end
endmodule : pmic_host_model
`default_nettype wire

// ### test_pmic_safety_config_regs.sv
// Testbench: configuration bank with state-machine model
`timescale 1ns/1ps
`default_nettype none
module test_pmic_safety_config_regs;
  logic       mclk = 1'b0;
  logic       rst  = 1'b1;
  logic       reg_wr_en, reg_rd_en, look, lock_mode_active, sm_interrupt_req, active_flag_state;
  logic       bus_timeout_clear, counter_clear_done, unlock_done, full_restart_done, restart_counter_clear;
  logic       lock_release, full_restart_req, active_flag_timeout, bus_timeout_error, interrupt_out_n, reset_out_n;
  logic [1:0] bus_timeout_sel, sel;
  logic       bus_checksum_enable, selftest_retry, spread_enable, spread_scheme_select, spread_depth_select;
  logic [2:0] spread_divider_select;
  logic [5:0] safe_state_restart_limit;
  logic [7:0] reg_addr, reg_wdata, reg_rd_data, v, obs, qr[$], qp[$];
  logic [7:0] lim[4] = '{8'h00, 8'h03, 8'h0F, 8'h3F};
  // Short ms timebase keeps the run small
  localparam int CYC = 10;
  int         srt[4] = '{pmic_cfg_pkg::SRT_T0_MS * CYC, pmic_cfg_pkg::SRT_T1_MS * CYC,
                         pmic_cfg_pkg::SRT_T2_MS * CYC, pmic_cfg_pkg::SRT_T3_MS * CYC};
  int         aft[4] = '{pmic_cfg_pkg::AFT_T1_MS * CYC, pmic_cfg_pkg::AFT_T1_MS * CYC,
                         pmic_cfg_pkg::AFT_T2_MS * CYC, pmic_cfg_pkg::AFT_T3_MS * CYC};
  int         n_mismatch = 0;
  int         comparisons = 0;
  pmic_safety_config_regs #(.CYC_PER_MS(CYC)) dut (.mclk, .rst,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rd_data, .counter_clear_done, .lock_mode_active,
    .unlock_done, .full_restart_done, .sm_interrupt_req, .active_flag_state, .bus_timeout_sel,
    .bus_timeout_clear, .bus_checksum_enable, .restart_counter_clear, .safe_state_restart_limit,
    .selftest_retry, .lock_release, .full_restart_req, .active_flag_timeout, .bus_timeout_error,
    .interrupt_out_n, .reset_out_n, .spread_enable, .spread_scheme_select, .spread_depth_select,
    .spread_divider_select);
  pmic_host_model host (.mclk, .rst, .restart_counter_clear, .lock_release, .full_restart_req,
    .counter_clear_done, .unlock_done, .full_restart_done);
  assign obs = (sel == 2'h0) ? {2'h0, safe_state_restart_limit} : (sel == 2'h1) ? {5'h0, spread_divider_select}
             : (sel == 2'h2) ? {4'h0, reset_out_n, interrupt_out_n, active_flag_timeout, bus_timeout_error}
             : {restart_counter_clear, lock_release, full_restart_req, spread_depth_select, spread_scheme_select,
                spread_enable, bus_checksum_enable, selftest_retry};
  always #5 mclk = ~mclk;
  task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error reg_rd_data expected %h seen %h", e, g);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error pin group %0d expected %h seen %h", sel, e, g);
    end
  endtask : cmp_pin
  always @(posedge mclk)
  begin
    if (reg_rd_en)
      cmp_reg(qr.pop_front(), reg_rd_data);
    if (look)
      cmp_pin(qp.pop_front(), obs);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge mclk);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    qr.push_back(e);
    @(negedge mclk);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge mclk);
    reg_rd_en = 1'b0;
  endtask : rd
  // Second expectation looks one cycle later; FF means none
  task automatic pin(input logic [1:0] s, input logic [7:0] e, input logic [7:0] e2 = 8'hFF);
    qp.push_back(e);
    if (e2 != 8'hFF)
      qp.push_back(e2);
    @(negedge mclk);
    sel  = s;
    look = 1'b1;
    @(negedge mclk);
    if (e2 != 8'hFF)
      @(negedge mclk);
    look = 1'b0;
  endtask : pin
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial
  begin
    #100000;
    n_mismatch++;
    $display("Error watchdog expected finish seen hang");
    wrap_up();
  end
  initial
  begin
    {reg_wr_en, reg_rd_en, look, lock_mode_active, sm_interrupt_req, active_flag_state, bus_timeout_clear} = '0;
    {reg_addr, reg_wdata, bus_timeout_sel, sel} = '0;
    v = 8'($urandom(59740));
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h0C);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h00);
    pin(2'h2, 8'h0C);
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h6D);
    pin(2'h3, 8'h83);
    repeat (6) @(negedge mclk);
    rd(8'h16, 8'h4D);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h16, 8'(c << 2) | 8'(c << 6) | 8'(c[1]));
      pin(2'h0, lim[c]);
      pin(2'h3, {6'h00, c[0], c[1]});
    end
    for (int i = 0; i < 8; i++)
    begin
      v = (8'($urandom) & 8'hF1) | 8'(i << 1);
      wr(8'h18, v);
      rd(8'h18, v & 8'h1F);
      pin(2'h1, (v[1] ? 8'h04 : 8'h01) + {6'h00, v[3:2]});
      pin(2'h3, {3'h0, v[4], v[1], v[0], 2'h3});
    end
    wr(8'h17, 8'h80);
    pin(2'h2, 8'h08);
    wr(8'h17, 8'h00);
    pin(2'h2, 8'h0C);
    sm_interrupt_req = 1'b1;
    pin(2'h2, 8'h08);
    sm_interrupt_req = 1'b0;
    wr(8'h17, 8'h40);
    rd(8'h17, 8'h00);
    lock_mode_active = 1'b1;
    wr(8'h17, 8'h40);
    pin(2'h3, {3'h2, v[4], v[1], v[0], 2'h3});
    rd(8'h17, 8'h40);
    repeat (6) @(negedge mclk);
    rd(8'h17, 8'h00);
    lock_mode_active = 1'b0;
    wr(8'h17, 8'h01);
    wr(8'h17, 8'h00);
    rd(8'h17, 8'h01);
    pin(2'h3, {3'h1, v[4], v[1], v[0], 2'h3});
    repeat (4) @(negedge mclk);
    rd(8'h17, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h17, 8'(c << 2) | 8'h02);
      rd(8'h17, 8'(c << 2) | 8'h02);
      pin(2'h2, 8'h04);
      repeat (srt[c] - 5) @(negedge mclk);
      pin(2'h2, 8'h04, 8'h0C);
      rd(8'h17, 8'(c << 2));
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h17, 8'(c << 4));
      active_flag_state = 1'b1;
      pin(2'h2, 8'h0C);
      repeat (aft[c] - 4) @(negedge mclk);
      pin(2'h2, 8'h0C, (c == 0) ? 8'h0C : 8'h0E);
      active_flag_state = 1'b0;
      pin(2'h2, 8'h0C);
    end
    bus_timeout_sel = 2'h1;
    repeat (pmic_cfg_pkg::BTO_T1_MS * CYC + 10) @(negedge mclk);
    pin(2'h2, 8'h09);
    bus_timeout_sel   = 2'h0;
    bus_timeout_clear = 1'b1;
    pin(2'h2, 8'h0C);
    bus_timeout_clear = 1'b0;
    wrap_up();
  end
endmodule : test_pmic_safety_config_regs
`default_nettype wire
